// ### qwlt_pkg.sv
// Shared constants for the quad-word link transmitter and its receiver
package qwlt_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] LINK_A_CONTROL_IDX = 8'h1b;
  localparam logic [7:0] LINK_B_CONTROL_IDX = 8'h1d;
  localparam logic [7:0] PORT_CLOCK_CONTROL_IDX = 8'h1e;
  localparam logic [7:0] DEV_STATUS_IDX = 8'h1f;
  localparam logic [7:0] RX_CONTROL_IDX = 8'h00;
  localparam logic [7:0] RX_STATUS_IDX = 8'h01;
  // ==========================================================
  // Field positions and reset values
  localparam int CTL_SRC_BIT = 0;
  localparam int CTL_MODE_BIT = 1;
  localparam int CTL_SIGNAL_STRENGTH_WORD_OFF_BIT = 2;
  localparam int CTL_WAIT_LSB = 3;
  localparam int CTL_WAIT_W = 4;
  localparam int PCC_MASTER_BIT = 0;
  localparam int PCC_DIV_LSB = 1;
  localparam int PCC_DIV_W = 2;
  localparam int RX_ENABLE_BIT = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PCC_RESET = 8'h00;
  // ==========================================================
  // Link framing and timing
  localparam int QUAD_BYTES = 16;
  localparam logic [3:0] LAST_BYTE = 4'hf;
  localparam logic [3:0] MIN_WAIT_PCLK = 4'h6;
  localparam logic [3:0] RX_PULSE_BYTE = 4'h2;
  localparam logic [2:0] RX_LOW_CYCLES = 3'h2;
endpackage

// ### qwlt_link_if.sv
// Byte-wide link between the transmitter and the receiver
`timescale 1ns/1ps
interface qwlt_link_if;
  // Byte on each edge of the forwarded clock
  logic [7:0] link_byte_out;
  // Forwarded output clock, low when idle
  logic link_forwarded_clock;
  // Ready and connectivity toggle from the receiver
  logic link_ready_input;
  modport dev (output link_byte_out, output link_forwarded_clock, input link_ready_input);
  modport rcv (input link_byte_out, input link_forwarded_clock, output link_ready_input);
endinterface

// ### qwlt_device.sv
// Two-port quad-word link transmitter with its Wishbone register file
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
module qwlt_device (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Wishbone classic slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [9:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // External port clock for slave mode
  input wire logic EXT_PORT_CLK,
  // Sample sources: IQ words {Q, I} and 12-bit strength words
  input wire logic [127:0] CH_IQ,
  input wire logic [31:0] GC_A_IQ,
  input wire logic [31:0] GC_B_IQ,
  input wire logic [11:0] GC_A_SIGNAL_STRENGTH_WORD,
  input wire logic [11:0] GC_B_SIGNAL_STRENGTH_WORD,
  // Link ports
  qwlt_link_if.dev LINK_A,
  qwlt_link_if.dev LINK_B
);
  typedef enum {TX_IDLE, TX_WAIT, TX_SEND} qwlt_tx_state_type;

  // ==========================================================
  // Register file
  logic [7:0] ctrl_reg [2]; // Link port control, A then B
  logic [7:0] pcc_reg; // Port clock control
  logic ack_reg; // Wishbone acknowledge
  logic [31:0] rdata_reg; // Wishbone read data
  logic req; // Fresh bus request
  logic [7:0] idx; // Register index
  logic [7:0] status; // Live status byte
  logic [1:0] busy; // Port is waiting or sending

  assign req = WB_CYC & WB_STB & ~ack_reg;
  assign idx = WB_ADR[9:2];
  assign WB_ACK = ack_reg;
  assign WB_DAT_O = rdata_reg;

  // Acknowledge one cycle after the request, any address
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // Register writes on the low byte lane
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl_reg[0] <= qwlt_pkg::CONTROL_RESET;
      ctrl_reg[1] <= qwlt_pkg::CONTROL_RESET;
      pcc_reg <= qwlt_pkg::PCC_RESET;
    end else if (req && WB_WE && WB_SEL[0]) begin
      if (idx == qwlt_pkg::LINK_A_CONTROL_IDX) begin
        ctrl_reg[0] <= WB_DAT_I[7:0];
      end else if (idx == qwlt_pkg::LINK_B_CONTROL_IDX) begin
        ctrl_reg[1] <= WB_DAT_I[7:0];
      end else if (idx == qwlt_pkg::PORT_CLOCK_CONTROL_IDX) begin
        pcc_reg <= WB_DAT_I[7:0];
      end
    end
  end

  assign status = {4'h0, g_port[1].sync2_reg, g_port[0].sync2_reg, busy};

  // Read mux, unmapped reads give zero
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rdata_reg <= 32'h0;
    end else if (req) begin
      case (idx)
        qwlt_pkg::LINK_A_CONTROL_IDX: rdata_reg <= {24'h0, ctrl_reg[0]};
        qwlt_pkg::LINK_B_CONTROL_IDX: rdata_reg <= {24'h0, ctrl_reg[1]};
        qwlt_pkg::PORT_CLOCK_CONTROL_IDX: rdata_reg <= {24'h0, pcc_reg};
        qwlt_pkg::DEV_STATUS_IDX: rdata_reg <= {24'h0, status};
        default: rdata_reg <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Port clock enable
  logic ext_prev_reg; // Last external clock level
  logic [2:0] div_cnt_reg; // Master divider count
  logic [2:0] div_top; // Terminal count for the divisor
  logic pclk_en; // One-cycle port clock tick

  assign div_top = 3'((4'h1 << pcc_reg[qwlt_pkg::PCC_DIV_LSB +: qwlt_pkg::PCC_DIV_W]) - 4'h1);

  // External edge detect and master divider
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ext_prev_reg <= 1'b0;
      div_cnt_reg <= 3'h0;
    end else begin
      ext_prev_reg <= EXT_PORT_CLK;
      // divide by 1, 2, 4 or 8
      if (div_cnt_reg >= div_top) begin
        div_cnt_reg <= 3'h0;
      end else begin
        div_cnt_reg <= div_cnt_reg + 3'h1;
      end
    end
  end

  always_comb begin
    if (pcc_reg[qwlt_pkg::PCC_MASTER_BIT]) begin
      pclk_en = (div_cnt_reg >= div_top);
    end else begin
      pclk_en = EXT_PORT_CLK & ~ext_prev_reg;
    end
  end

  // ==========================================================
  // Link port engines
  logic [1:0] ready_in; // Raw ready pins
  logic [31:0] own_iq [2]; // Port's own gain-control stage
  logic [11:0] own_signal_strength_word [2];

  assign ready_in = {LINK_B.link_ready_input, LINK_A.link_ready_input};
  assign own_iq[0] = GC_A_IQ;
  assign own_iq[1] = GC_B_IQ;
  assign own_signal_strength_word[0] = GC_A_SIGNAL_STRENGTH_WORD;
  assign own_signal_strength_word[1] = GC_B_SIGNAL_STRENGTH_WORD;

  for (genvar p = 0; p < 2; p++) begin : g_port
    qwlt_tx_state_type state_reg; // Port state
    logic sync1_reg; // First synchroniser stage
    logic sync2_reg; // Synchronised ready
    logic [3:0] wait_cnt_reg; // Port clocks waited
    logic [3:0] byte_idx_reg; // Next byte in the quad-word
    logic [127:0] quad_reg; // Quad-word being sent
    logic [7:0] byte_reg; // Byte on the pins
    logic fclk_reg; // Forwarded clock
    logic low_seen_reg; // Ready went low in this quad
    logic pulse_seen_reg; // Ready went low then high
    logic [7:0] ctl; // This port's control
    logic [3:0] wait_target; // Effective wait length
    logic [127:0] quad_next; // Quad-word to load
    logic [31:0] gc_iq; // Selected stage pair
    logic [15:0] signal_strength_word_word; // Padded signal strength
    logic [31:0] ch_x; // Channel pair, first
    logic [31:0] ch_y; // Channel pair, second
    logic signal_strength_word_on; // Strength word included
    logic at_last; // Last byte is going out

    assign ctl = ctrl_reg[p];
    assign at_last = (byte_idx_reg == qwlt_pkg::LAST_BYTE);

    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        sync1_reg <= 1'b0;
        sync2_reg <= 1'b0;
      end else begin
        sync1_reg <= ready_in[p];
        sync2_reg <= sync1_reg;
      end
    end

    // software sizes the field for the ratio
    always_comb begin
      wait_target = ctl[qwlt_pkg::CTL_WAIT_LSB +: qwlt_pkg::CTL_WAIT_W];
      if (wait_target < qwlt_pkg::MIN_WAIT_PCLK) begin
        wait_target = qwlt_pkg::MIN_WAIT_PCLK;
      end
    end

    // format select for the next quad-word
    always_comb begin
      // bit 1 clear keeps the port's own stage
      // bit 1 set sends stage A on both ports
      gc_iq = ctl[qwlt_pkg::CTL_MODE_BIT] ? GC_A_IQ : own_iq[p];
      signal_strength_word_word = {(ctl[qwlt_pkg::CTL_MODE_BIT] ? GC_A_SIGNAL_STRENGTH_WORD : own_signal_strength_word[p]), 4'h0};
      // forbidden combination falls back to strength words
      signal_strength_word_on = ~ctl[qwlt_pkg::CTL_SIGNAL_STRENGTH_WORD_OFF_BIT] | ~ctl[qwlt_pkg::CTL_MODE_BIT];
      ch_x = ctl[qwlt_pkg::CTL_SIGNAL_STRENGTH_WORD_OFF_BIT] ? CH_IQ[95:64] : CH_IQ[31:0];
      ch_y = ctl[qwlt_pkg::CTL_SIGNAL_STRENGTH_WORD_OFF_BIT] ? CH_IQ[127:96] : CH_IQ[63:32];
      // each pair {Q, I}, four pairs fill 16 bytes
      if (!ctl[qwlt_pkg::CTL_SRC_BIT]) begin
        if (ctl[qwlt_pkg::CTL_MODE_BIT]) begin
          quad_next = {ch_y, ch_x, ch_y, ch_x};
        end else begin
          quad_next = CH_IQ;
        end
      end else if (signal_strength_word_on) begin
        // strength word then two zero bytes
        quad_next = {16'h0, signal_strength_word_word, gc_iq, 16'h0, signal_strength_word_word, gc_iq};
      end else begin
        quad_next = {gc_iq, gc_iq, gc_iq, gc_iq};
      end
    end

    // Port sequencer
    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        state_reg <= TX_IDLE;
        wait_cnt_reg <= 4'h0;
        byte_idx_reg <= 4'h0;
        quad_reg <= 128'h0;
      end else begin
        case (state_reg)
          TX_IDLE: begin
            if (sync2_reg) begin
              state_reg <= TX_WAIT;
              wait_cnt_reg <= 4'h0;
            end
          end
          TX_WAIT: begin
            if (!sync2_reg) begin
              state_reg <= TX_IDLE;
            end else if (pclk_en) begin
              if (wait_cnt_reg == wait_target - 4'h1) begin
                state_reg <= TX_SEND;
                quad_reg <= quad_next;
                byte_idx_reg <= 4'h0;
              end else begin
                wait_cnt_reg <= wait_cnt_reg + 4'h1;
              end
            end
          end
          TX_SEND: begin
            if (pclk_en) begin
              byte_idx_reg <= byte_idx_reg + 4'h1;
              if (at_last) begin
                if (pulse_seen_reg && sync2_reg) begin
                  quad_reg <= quad_next;
                end else begin
                  state_reg <= TX_IDLE;
                end
              end
            end
          end
          default: state_reg <= TX_IDLE;
        endcase
      end
    end

    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        low_seen_reg <= 1'b0;
        pulse_seen_reg <= 1'b0;
      end else begin
        if (state_reg != TX_SEND || (pclk_en && at_last)) begin
          low_seen_reg <= 1'b0;
          pulse_seen_reg <= 1'b0;
        end
        if (state_reg == TX_SEND && !sync2_reg) begin
          low_seen_reg <= 1'b1;
        end
        if (state_reg == TX_SEND && low_seen_reg && sync2_reg) begin
          pulse_seen_reg <= 1'b1;
        end
      end
    end

    // Byte and forwarded clock pins
    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        byte_reg <= 8'h0;
        fclk_reg <= 1'b0;
      end else if (state_reg == TX_SEND && pclk_en) begin
        // low byte first, I before Q
        byte_reg <= quad_reg[{byte_idx_reg, 3'h0} +: 8];
        fclk_reg <= ~fclk_reg;
      end
    end

    assign busy[p] = (state_reg != TX_IDLE);
  end

  assign LINK_A.link_byte_out = g_port[0].byte_reg;
  assign LINK_A.link_forwarded_clock = g_port[0].fclk_reg;
  assign LINK_B.link_byte_out = g_port[1].byte_reg;
  assign LINK_B.link_forwarded_clock = g_port[1].fclk_reg;
endmodule // qwlt_device

// ### qwlt_receiver.sv
// Link receiver end: raises ready, toggles it per quad-word, assembles bytes
`timescale 1ns/1ps
module qwlt_receiver (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Wishbone classic slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [9:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // Received quad-words
  output logic [127:0] QUAD_DATA,
  output logic QUAD_VALID,
  // Link
  qwlt_link_if.rcv LINK
);
  // ==========================================================
  // Registers
  logic ack_reg; // Wishbone acknowledge
  logic [31:0] rdata_reg; // Wishbone read data
  logic enable_reg; // Receive enabled
  logic [15:0] count_reg; // Quad-words received
  logic [3:0] byte_cnt_reg; // Bytes of current quad-word
  logic req; // Fresh bus request
  logic [7:0] idx; // Register index

  assign req = WB_CYC & WB_STB & ~ack_reg;
  assign idx = WB_ADR[9:2];
  assign WB_ACK = ack_reg;
  assign WB_DAT_O = rdata_reg;

  // Bus answer one cycle after the request
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
      enable_reg <= 1'b0;
    end else begin
      ack_reg <= req;
      if (req && WB_WE && WB_SEL[0] && idx == qwlt_pkg::RX_CONTROL_IDX) begin
        enable_reg <= WB_DAT_I[qwlt_pkg::RX_ENABLE_BIT];
      end
      if (req) begin
        case (idx)
          qwlt_pkg::RX_CONTROL_IDX: rdata_reg <= {31'h0, enable_reg};
          qwlt_pkg::RX_STATUS_IDX: rdata_reg <= {12'h0, byte_cnt_reg, count_reg};
          default: rdata_reg <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // Byte capture
  logic fprev_reg; // Last forwarded clock level
  logic [127:0] asm_reg; // Assembly buffer
  logic [127:0] quad_out_reg; // Completed quad-word
  logic valid_reg; // Completion pulse
  logic edge_seen; // Either clock edge

  assign edge_seen = LINK.link_forwarded_clock ^ fprev_reg;

  // Sample a byte on each forwarded edge
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      fprev_reg <= 1'b0;
      byte_cnt_reg <= 4'h0;
      asm_reg <= 128'h0;
      quad_out_reg <= 128'h0;
      valid_reg <= 1'b0;
      count_reg <= 16'h0;
    end else begin
      fprev_reg <= LINK.link_forwarded_clock;
      valid_reg <= 1'b0;
      if (edge_seen) begin
        byte_cnt_reg <= byte_cnt_reg + 4'h1;
        asm_reg[{byte_cnt_reg, 3'h0} +: 8] <= LINK.link_byte_out;
        if (byte_cnt_reg == qwlt_pkg::LAST_BYTE) begin
          quad_out_reg <= {LINK.link_byte_out, asm_reg[119:0]};
          valid_reg <= 1'b1;
          count_reg <= count_reg + 16'h1;
        end
      end
    end
  end

  assign QUAD_DATA = quad_out_reg;
  assign QUAD_VALID = valid_reg;

  // ==========================================================
  // Ready and connectivity toggle
  logic ready_reg; // Ready pin
  logic [2:0] low_cnt_reg; // Remaining low cycles

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ready_reg <= 1'b0;
      low_cnt_reg <= 3'h0;
    end else if (edge_seen && byte_cnt_reg == qwlt_pkg::RX_PULSE_BYTE) begin
      ready_reg <= 1'b0;
      low_cnt_reg <= qwlt_pkg::RX_LOW_CYCLES;
    end else if (low_cnt_reg != 3'h0) begin
      low_cnt_reg <= low_cnt_reg - 3'h1;
    end else begin
      ready_reg <= enable_reg;
    end
  end

  assign LINK.link_ready_input = ready_reg;
endmodule // qwlt_receiver

// ### qwlt_link_sva.sv
// Concurrent checks on the byte link between transmitter and receiver
`timescale 1ns/1ps
module qwlt_link_sva (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Link signals
  input wire logic [7:0] link_byte_out,
  input wire logic link_forwarded_clock,
  input wire logic link_ready_input
);
  // ==========================================================
  // Helper state
  logic clk_prev_reg; // Forwarded clock one cycle ago
  logic [3:0] edge_cnt_reg; // Clock edges within the quad-word
  logic [3:0] rdy_run_reg; // Cycles ready has stayed high
  logic [5:0] gap_reg; // Cycles since the last clock edge
  logic seen_reg; // Ready pulse seen in this quad-word
  logic cont_reg; // Last quad-word ended with a pulse seen
  logic toggle; // Forwarded clock changed this cycle
  assign toggle = link_forwarded_clock ^ clk_prev_reg;

  // Track edges, ready runs and gaps
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      clk_prev_reg <= 1'b0;
      edge_cnt_reg <= 4'h0;
      rdy_run_reg <= 4'h0;
      gap_reg <= 6'h3f;
      seen_reg <= 1'b0;
      cont_reg <= 1'b0;
    end else begin
      clk_prev_reg <= link_forwarded_clock;
      edge_cnt_reg <= edge_cnt_reg + {3'h0, toggle};
      rdy_run_reg <= !link_ready_input ? 4'h0 : (rdy_run_reg == 4'hf ? 4'hf : rdy_run_reg + 4'h1);
      gap_reg <= toggle ? 6'h00 : (gap_reg == 6'h3f ? 6'h3f : gap_reg + 6'h01);
      // Pulse flag cleared at the last edge
      if (toggle && edge_cnt_reg == 4'hf) begin
        seen_reg <= 1'b0;
      end else if (!link_ready_input && edge_cnt_reg != 4'h0) begin
        seen_reg <= 1'b1;
      end
      if (toggle) begin
        cont_reg <= (edge_cnt_reg == 4'hf) && (seen_reg || !link_ready_input);
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  AST_BYTE_WITH_EDGE: assert property (!$stable(link_byte_out) |-> toggle)
    else $error("link byte changed without a clock edge");
  AST_GAP_BOUND: assert property (edge_cnt_reg != 4'h0 |-> gap_reg < 6'd40)
    else $error("quad-word stalled in mid transfer");
  AST_WAIT_SIX: assert property (toggle && edge_cnt_reg == 4'h0 && !cont_reg |->
    rdy_run_reg >= 4'h6)
    else $error("transfer began less than six cycles after ready");
  AST_NO_STREAM_UNPULSED: assert property (toggle && edge_cnt_reg == 4'h0 && !cont_reg |->
    gap_reg >= 6'd6)
    else $error("next quad-word streamed without a ready pulse");
  AST_STREAM_ON: assert property (toggle && edge_cnt_reg == 4'hf && seen_reg |->
    ##[1:20] toggle)
    else $error("stream stopped after a ready pulse");
  AST_RDY_PULSE: assert property ($fell(link_ready_input) && edge_cnt_reg != 4'h0 |->
    edge_cnt_reg >= 4'h3 ##1 !link_ready_input ##1 !link_ready_input ##1 link_ready_input)
    else $error("ready pulse has wrong place or length");
  AST_RESET_QUIET: assert property ($fell(SRST) |->
    !link_forwarded_clock && !link_ready_input && link_byte_out == 8'h00)
    else $error("link not quiet after reset");
  AST_IDLE_NO_EDGE: assert property (rdy_run_reg == 4'h0 && edge_cnt_reg == 4'h0 && !cont_reg
    |-> !toggle)
    else $error("clock edge while ready low and idle");
endmodule // qwlt_link_sva

// ### tb.sv
// Self-checking bench joining the transmitter to two receivers
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Signals
  logic core_clk, srst, we, ext_clk; // Clock, reset, bus direction, port clock
  logic [1:0] ext_cnt; // Port clock divider
  logic [2:0] cyc; // Bus request per slave
  logic [7:0] adr_idx; // Register index
  logic [31:0] wdat; // Write data
  logic [31:0] rdat [3]; // Read data per slave
  logic [2:0] ack; // Acknowledge per slave
  logic [127:0] ch_iq; // Channel sources
  logic [31:0] gc_a_iq, gc_b_iq; // Gain-control pairs
  logic [11:0] gc_a_signal_strength_word, gc_b_signal_strength_word; // Strength words
  logic [127:0] qd [2]; // Received quad-words
  logic [1:0] qv; // Quad-word valid pulses
  int fails, n_tests;
  // wait of six suits equal link clock rates
  localparam logic [7:0] CFG [7] = '{8'h30, 8'h32, 8'h36, 8'h31, 8'h33, 8'h37, 8'h35};
  qwlt_link_if link_a ();
  qwlt_link_if link_b ();

  // ==========================================================
  // Instances
  qwlt_device qwlt_device_i (.CORE_CLK(core_clk), .SRST(srst), .WB_CYC(cyc[0]),
    .WB_STB(cyc[0]), .WB_WE(we), .WB_ADR({adr_idx, 2'b00}), .WB_SEL(4'hf), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat[0]), .WB_ACK(ack[0]), .EXT_PORT_CLK(ext_clk), .CH_IQ(ch_iq),
    .GC_A_IQ(gc_a_iq), .GC_B_IQ(gc_b_iq), .GC_A_SIGNAL_STRENGTH_WORD(gc_a_signal_strength_word), .GC_B_SIGNAL_STRENGTH_WORD(gc_b_signal_strength_word),
    .LINK_A(link_a), .LINK_B(link_b));
  qwlt_receiver qwlt_receiver_i (.CORE_CLK(core_clk), .SRST(srst), .WB_CYC(cyc[1]),
    .WB_STB(cyc[1]), .WB_WE(we), .WB_ADR({adr_idx, 2'b00}), .WB_SEL(4'hf), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat[1]), .WB_ACK(ack[1]), .QUAD_DATA(qd[0]), .QUAD_VALID(qv[0]), .LINK(link_a));
  qwlt_receiver qwlt_receiver_b_i (.CORE_CLK(core_clk), .SRST(srst), .WB_CYC(cyc[2]),
    .WB_STB(cyc[2]), .WB_WE(we), .WB_ADR({adr_idx, 2'b00}), .WB_SEL(4'hf), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat[2]), .WB_ACK(ack[2]), .QUAD_DATA(qd[1]), .QUAD_VALID(qv[1]), .LINK(link_b));
  qwlt_link_sva qwlt_link_sva_i (.CORE_CLK(core_clk), .SRST(srst),
    .link_byte_out(link_a.link_byte_out), .link_forwarded_clock(link_a.link_forwarded_clock),
    .link_ready_input(link_a.link_ready_input));

  // ==========================================================
  // Clocks: core clock and a slave-mode port clock of six cycles
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    ext_cnt <= (ext_cnt == 2'd2) ? 2'd0 : ext_cnt + 2'd1;
    if (ext_cnt == 2'd2) ext_clk <= ~ext_clk;
  end

  // ==========================================================
  // Tasks
  // Classic Wishbone single cycle on slave t
  task automatic wb(input int t, input logic w, input logic [7:0] idx,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    cyc[t] <= 1'b1;
    we <= w;
    adr_idx <= idx;
    wdat <= d;
    do @(posedge core_clk); while (ack[t] !== 1'b1);
    q = rdat[t];
    cyc[t] <= 1'b0;
  endtask
  // Register read and compare
  task automatic rd_chk(input int t, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    wb(t, 1'b0, idx, 32'h0, q);
    n_tests++;
    if (q !== exp) begin
      fails++;
      $display("unexpected register at %0t: got %h exp %h", $time, q, exp);
    end
  endtask
  // Wait for the next quad-word on port p and compare
  task automatic get_quad(input int p, input logic [127:0] exp);
    do @(posedge core_clk); while (qv[p] !== 1'b1);
    n_tests++;
    if (qd[p] !== exp) begin
      fails++;
      $display("unexpected quad at %0t: got %h exp %h", $time, qd[p], exp);
    end
  endtask
  // Expected quad-word for a control value on port p
  function automatic logic [127:0] exp_q(input logic [7:0] c, input int p);
    logic [31:0] pr;
    logic [31:0] sw;
    if (!c[0]) begin
      if (!c[1]) return ch_iq;
      return c[2] ? {2{ch_iq[127:64]}} : {2{ch_iq[63:0]}};
    end
    pr = (c[1] || p == 0) ? gc_a_iq : gc_b_iq;
    sw = {16'h0, (c[1] || p == 0) ? gc_a_signal_strength_word : gc_b_signal_strength_word, 4'h0};
    if (c[1] && c[2]) return {4{pr}};
    return {sw, pr, sw, pr};
  endfunction
  // Verdict and end of run
  task automatic test_done;
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (50000) @(posedge core_clk);
    fails++;
    test_done;
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    logic [31:0] pcc;
    logic [7:0] c;
    fails = 0;
    n_tests = 0;
    cyc = 3'h0;
    we = 1'b0;
    adr_idx = 8'h00;
    wdat = 32'h0;
    ext_clk = 1'b0;
    ext_cnt = 2'd0;
    ch_iq = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
    gc_a_iq = 32'h8a7b6c5d;
    gc_b_iq = 32'h13243546;
    gc_a_signal_strength_word = 12'h9e1;
    gc_b_signal_strength_word = 12'h2c7;
    srst = 1'b1;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk(0, qwlt_pkg::LINK_A_CONTROL_IDX, 32'h0);
    rd_chk(0, qwlt_pkg::LINK_B_CONTROL_IDX, 32'h0);
    rd_chk(0, qwlt_pkg::PORT_CLOCK_CONTROL_IDX, 32'h0);
    rd_chk(0, 8'h10, 32'h0);
    // Every format, the forbidden one included, across all five port clock choices
    for (int i = 0; i < 7; i++) begin
      c = CFG[i];
      pcc = (i == 5) ? 32'h0 : {29'h0, i[1:0], 1'b1};
      wb(0, 1'b1, qwlt_pkg::LINK_A_CONTROL_IDX, {24'h0, c}, q);
      wb(0, 1'b1, qwlt_pkg::LINK_B_CONTROL_IDX, {24'h0, c}, q);
      wb(0, 1'b1, qwlt_pkg::PORT_CLOCK_CONTROL_IDX, pcc, q);
      rd_chk(0, qwlt_pkg::LINK_B_CONTROL_IDX, {24'h0, c});
      rd_chk(0, qwlt_pkg::PORT_CLOCK_CONTROL_IDX, pcc);
      wb(1, 1'b1, qwlt_pkg::RX_CONTROL_IDX, 32'h1, q);
      wb(2, 1'b1, qwlt_pkg::RX_CONTROL_IDX, 32'h1, q);
      rd_chk(1, qwlt_pkg::RX_CONTROL_IDX, 32'h1);
      rd_chk(2, qwlt_pkg::RX_CONTROL_IDX, 32'h1);
      fork
        begin
          get_quad(0, exp_q(c, 0));
          get_quad(0, exp_q(c, 0));
        end
        begin
          get_quad(1, exp_q(c, 1));
          get_quad(1, exp_q(c, 1));
        end
      join
      // Reset in mid stream
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      rd_chk(0, qwlt_pkg::PORT_CLOCK_CONTROL_IDX, 32'h0);
      rd_chk(0, qwlt_pkg::DEV_STATUS_IDX, 32'h0);
    end
    test_done;
  end
endmodule // tb
